// >>> inc/pic_pkg.sv
package pic_pkg;

    // Byte offsets on the register bus
    localparam logic [7:0] OFS_PRIMARY   = 8'h00;
    localparam logic [7:0] OFS_SECONDARY = 8'h04;
    localparam logic [7:0] OFS_TERTIARY  = 8'h08;
    localparam logic [7:0] OFS_EXTRA     = 8'h0C;
    localparam logic [7:0] OFS_EDGE_SEL  = 8'h10;

    // Implemented bits of each register
    localparam logic [7:0] MASK_PRIMARY   = 8'h7F;
    localparam logic [7:0] MASK_SECONDARY = 8'hFF;
    localparam logic [7:0] MASK_TERTIARY  = 8'hFF;
    localparam logic [7:0] MASK_EXTRA     = 8'h33;
    localparam logic [7:0] MASK_EDGE_SEL  = 8'hFF;

    localparam logic [7:0] RST_CTRL = 8'h00;

    // Primary register fields
    localparam int BIT_CMP_ZERO_F  = 6;
    localparam int BIT_EXT_ONE_F   = 5;
    localparam int BIT_EXT_ZERO_F  = 4;
    localparam int BIT_CMP_ZERO_E  = 3;
    localparam int BIT_EXT_ONE_E   = 2;
    localparam int BIT_EXT_ZERO_E  = 1;
    localparam int BIT_GLOBAL_E    = 0;
    // Secondary register fields
    localparam int BIT_ADC_F       = 7;
    localparam int BIT_MF_ONE_F    = 6;
    localparam int BIT_MF_ZERO_F   = 5;
    localparam int BIT_CMP_ONE_F   = 4;
    // Tertiary register fields
    localparam int BIT_MF_THREE_F  = 7;
    localparam int BIT_TB_ONE_F    = 6;
    localparam int BIT_TB_ZERO_F   = 5;
    localparam int BIT_MF_TWO_F    = 4;
    // Extra pin register fields
    localparam int BIT_EXT_THREE_F = 5;
    localparam int BIT_EXT_TWO_F   = 4;
    localparam int BIT_EXT_THREE_E = 1;
    localparam int BIT_EXT_TWO_E   = 0;

    // Two-bit edge selection per external pin
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    localparam int NUM_EXT_PINS = 4;
    localparam int NUM_SOURCES  = 13;

endpackage : pic_pkg

// >>> src/pic_sync2.sv
module pic_sync2 (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Asynchronous level in, synchronised level out
    input  wire logic async_i,
    output logic      sync_o
);

    logic meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : pic_sync2

// >>> src/pic_edge_det.sv
module pic_edge_det (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Synchronised pin level and edge selection
    input  wire logic       level_i,
    input  wire logic [1:0] sel_i,
    // One-cycle event
    output logic            evt_o
);

    logic prev_q;
    logic prime_q;

    // Priming masks the first cycle after reset; a pin high out of reset still gives a rising edge, as the synchroniser resets low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q  <= 1'b0;
            prime_q <= 1'b0;
        end else begin
            prev_q  <= level_i;
            prime_q <= 1'b1;
        end
    end

    always_comb begin
        evt_o = 1'b0;
        if (prime_q) begin
            case (sel_i)
                pic_pkg::EDGE_RISE: evt_o = level_i & ~prev_q;
                pic_pkg::EDGE_FALL: evt_o = ~level_i & prev_q;
                pic_pkg::EDGE_BOTH: evt_o = level_i ^ prev_q;
                default:            evt_o = 1'b0;
            endcase
        end
    end

    chk_edge_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        sel_i == pic_pkg::EDGE_OFF |-> !evt_o)
        else $error("edge event while detection disabled");

    chk_edge_rise_seen: assert property (@(posedge clk_i) disable iff (rst_i)
        prime_q && sel_i == pic_pkg::EDGE_RISE && $rose(level_i) |-> evt_o)
        else $error("rising edge not reported");

endmodule : pic_edge_det

// >>> src/pic_intc_regs.sv
module pic_intc_regs #(
    parameter bit EXTRA_PINS = 1'b1
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Internal event pulses
    input  wire logic [1:0]  cmp_evt_i,
    input  wire logic        adc_evt_i,
    input  wire logic [3:0]  mf_evt_i,
    input  wire logic [1:0]  tb_evt_i,
    // External interrupt pins
    input  wire logic [3:0]  ext_pin_i,
    // Request to the core
    output logic             irq_o,
    output logic [3:0]       irq_vec_o
);

    localparam int NUM_SRC_W = pic_pkg::NUM_SOURCES;

    logic [7:0] ctrl_q [4];
    logic [7:0] ctrl_mask [4];
    logic [7:0] ctrl_ofs [4];
    logic [7:0] set_vec [4];
    logic [7:0] edge_sel_q;
    logic [3:0] ext_sync;
    logic [3:0] ext_evt;
    logic [3:0] wr_hit;
    logic       bus_req;
    logic       bus_wr;
    logic       edge_wr;
    logic [7:0] rd_byte;
    logic [NUM_SRC_W-1:0] src_pend;
    logic       any_pend;
    logic [3:0] vec_d;

    // Unused variant hides the extra pin register completely
    always_comb begin
        ctrl_mask[0] = pic_pkg::MASK_PRIMARY;
        ctrl_mask[1] = pic_pkg::MASK_SECONDARY;
        ctrl_mask[2] = pic_pkg::MASK_TERTIARY;
        ctrl_mask[3] = EXTRA_PINS ? pic_pkg::MASK_EXTRA : 8'h00;
        ctrl_ofs[0]  = pic_pkg::OFS_PRIMARY;
        ctrl_ofs[1]  = pic_pkg::OFS_SECONDARY;
        ctrl_ofs[2]  = pic_pkg::OFS_TERTIARY;
        ctrl_ofs[3]  = pic_pkg::OFS_EXTRA;
    end

    // Bus slave: ack one cycle after the request, for every address
    // A write lands on the edge where the master samples ack, not earlier
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if ({wb_adr_i[7:2], 2'b00} == pic_pkg::OFS_PRIMARY) begin
            rd_byte = ctrl_q[0];
        end else if ({wb_adr_i[7:2], 2'b00} == pic_pkg::OFS_SECONDARY) begin
            rd_byte = ctrl_q[1];
        end else if ({wb_adr_i[7:2], 2'b00} == pic_pkg::OFS_TERTIARY) begin
            rd_byte = ctrl_q[2];
        end else if ({wb_adr_i[7:2], 2'b00} == pic_pkg::OFS_EXTRA) begin
            rd_byte = ctrl_q[3];
        end else if ({wb_adr_i[7:2], 2'b00} == pic_pkg::OFS_EDGE_SEL) begin
            rd_byte = edge_sel_q;
        end else begin
            rd_byte = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // External pins: synchronise, then detect the chosen edge
    for (genvar p = 0; p < pic_pkg::NUM_EXT_PINS; p++) begin : g_pin
        logic [1:0] pin_sel;
        assign pin_sel = (p < 2 || EXTRA_PINS) ? edge_sel_q[2*p+1:2*p] : pic_pkg::EDGE_OFF;

        pic_sync2 u_sync (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .async_i (ext_pin_i[p]),
            .sync_o  (ext_sync[p])
        );

        pic_edge_det u_edge (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .level_i (ext_sync[p]),
            .sel_i   (pin_sel),
            .evt_o   (ext_evt[p])
        );
    end

    assign edge_wr = bus_wr && {wb_adr_i[7:2], 2'b00} == pic_pkg::OFS_EDGE_SEL;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_sel_q <= pic_pkg::RST_CTRL;
        end else if (edge_wr) begin
            edge_sel_q <= wb_dat_i[7:0] & pic_pkg::MASK_EDGE_SEL;
        end
    end

    // Hardware events placed at their flag positions
    always_comb begin
        set_vec[0] = 8'h00;
        set_vec[1] = 8'h00;
        set_vec[2] = 8'h00;
        set_vec[3] = 8'h00;
        set_vec[0][pic_pkg::BIT_CMP_ZERO_F]  = cmp_evt_i[0];
        set_vec[0][pic_pkg::BIT_EXT_ONE_F]   = ext_evt[1];
        set_vec[0][pic_pkg::BIT_EXT_ZERO_F]  = ext_evt[0];
        set_vec[1][pic_pkg::BIT_ADC_F]       = adc_evt_i;
        set_vec[1][pic_pkg::BIT_MF_ONE_F]    = mf_evt_i[1];
        set_vec[1][pic_pkg::BIT_MF_ZERO_F]   = mf_evt_i[0];
        set_vec[1][pic_pkg::BIT_CMP_ONE_F]   = cmp_evt_i[1];
        set_vec[2][pic_pkg::BIT_MF_THREE_F]  = mf_evt_i[3];
        set_vec[2][pic_pkg::BIT_TB_ONE_F]    = tb_evt_i[1];
        set_vec[2][pic_pkg::BIT_TB_ZERO_F]   = tb_evt_i[0];
        set_vec[2][pic_pkg::BIT_MF_TWO_F]    = mf_evt_i[2];
        set_vec[3][pic_pkg::BIT_EXT_THREE_F] = ext_evt[3];
        set_vec[3][pic_pkg::BIT_EXT_TWO_F]   = ext_evt[2];
    end

    // Control registers; an event in a write cycle still sets its flag
    for (genvar r = 0; r < 4; r++) begin : g_ctrl
        assign wr_hit[r] = bus_wr && {wb_adr_i[7:2], 2'b00} == ctrl_ofs[r];

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                ctrl_q[r] <= pic_pkg::RST_CTRL;
            end else if (wr_hit[r]) begin
                ctrl_q[r] <= (wb_dat_i[7:0] | set_vec[r]) & ctrl_mask[r];
            end else begin
                ctrl_q[r] <= (ctrl_q[r] | set_vec[r]) & ctrl_mask[r];
            end
        end
    end

    // Per-source pending, index 0 has the highest priority
    always_comb begin
        src_pend[0]  = ctrl_q[0][pic_pkg::BIT_EXT_ZERO_F] & ctrl_q[0][pic_pkg::BIT_EXT_ZERO_E];
        src_pend[1]  = ctrl_q[0][pic_pkg::BIT_EXT_ONE_F] & ctrl_q[0][pic_pkg::BIT_EXT_ONE_E];
        src_pend[2]  = ctrl_q[0][pic_pkg::BIT_CMP_ZERO_F] & ctrl_q[0][pic_pkg::BIT_CMP_ZERO_E];
        src_pend[3]  = ctrl_q[1][4] & ctrl_q[1][0];
        src_pend[4]  = ctrl_q[1][5] & ctrl_q[1][1];
        src_pend[5]  = ctrl_q[1][6] & ctrl_q[1][2];
        src_pend[6]  = ctrl_q[1][7] & ctrl_q[1][3];
        src_pend[7]  = ctrl_q[2][4] & ctrl_q[2][0];
        src_pend[8]  = ctrl_q[2][5] & ctrl_q[2][1];
        src_pend[9]  = ctrl_q[2][6] & ctrl_q[2][2];
        src_pend[10] = ctrl_q[2][7] & ctrl_q[2][3];
        src_pend[11] = ctrl_q[3][pic_pkg::BIT_EXT_TWO_F] & ctrl_q[3][pic_pkg::BIT_EXT_TWO_E];
        src_pend[12] = ctrl_q[3][pic_pkg::BIT_EXT_THREE_F] & ctrl_q[3][pic_pkg::BIT_EXT_THREE_E];
    end

    assign any_pend = |src_pend;

    always_comb begin
        vec_d = 4'h0;
        for (int i = NUM_SRC_W - 1; i >= 0; i--) begin
            if (src_pend[i]) begin
                vec_d = 4'(i);
            end
        end
    end

    // Global enable gates the single request line
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o     <= 1'b0;
            irq_vec_o <= 4'h0;
        end else begin
            irq_o     <= ctrl_q[0][pic_pkg::BIT_GLOBAL_E] & any_pend;
            irq_vec_o <= vec_d;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_reset_all_zero: assert property (
        $past(rst_i) |-> (ctrl_q[0] | ctrl_q[1] | ctrl_q[2] | ctrl_q[3] | edge_sel_q) == 8'h00)
        else $error("registers not cleared by reset");

    chk_reserved_bits_zero: assert property (
        !ctrl_q[0][7] && (ctrl_q[3] & 8'hCC) == 8'h00)
        else $error("unimplemented bit reads one");

    chk_cmp_flag_set: assert property (
        cmp_evt_i[0] |=> ctrl_q[0][pic_pkg::BIT_CMP_ZERO_F])
        else $error("comparator 0 event lost");

    chk_event_beats_clear: assert property (
        wr_hit[1] && !wb_dat_i[7] && adc_evt_i |=> ctrl_q[1][7])
        else $error("clear won over event");

    chk_enable_written: assert property (
        wr_hit[0] |=> ctrl_q[0][3:0] == $past(wb_dat_i[3:0]))
        else $error("enable bits not stored");

    chk_secondary_bits: assert property (
        wr_hit[1] && set_vec[1] == 8'h00 |=> ctrl_q[1] == $past(wb_dat_i[7:0]))
        else $error("secondary register layout wrong");

    chk_tertiary_bits: assert property (
        tb_evt_i[1] |=> ctrl_q[2][6])
        else $error("time base 1 flag not at bit 6");

    chk_extra_pin_flag: assert property (
        EXTRA_PINS && ext_evt[3] |=> ctrl_q[3][5])
        else $error("pin 3 flag not at bit 5");

    chk_global_gate: assert property (
        !ctrl_q[0][pic_pkg::BIT_GLOBAL_E] |=> !irq_o)
        else $error("request with global enable clear");

    chk_request_path: assert property (
        ctrl_q[0][0] && ctrl_q[0][6] && ctrl_q[0][3] |=> irq_o ##0 irq_vec_o <= 4'h2)
        else $error("enabled flag gave no request");

    chk_ack_one_cycle: assert property (
        bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single cycle");

    // Bus reads and writes
    chk_no_stray_ack: assert property (
        !bus_req |=> !wb_ack_o)
        else $error("ack without a request");

    chk_read_primary: assert property (
        bus_req && !wb_we_i && wb_adr_i == pic_pkg::OFS_PRIMARY
            |=> wb_dat_o[7:0] == $past(ctrl_q[0]))
        else $error("primary register read wrong");

    chk_read_unmapped: assert property (
        bus_req && !wb_we_i && wb_adr_i[7:2] > 6'h04 |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped address read nonzero");

    chk_sel_gates_write: assert property (
        wb_cyc_i && wb_stb_i && wb_ack_o && !wb_sel_i[0] && set_vec[0] == 8'h00
            |=> ctrl_q[0] == $past(ctrl_q[0]))
        else $error("write with byte lane off took effect");

    chk_unmapped_write_ignored: assert property (
        wb_cyc_i && wb_stb_i && wb_ack_o && wb_adr_i[7:2] > 6'h04 && set_vec[1] == 8'h00
            |=> ctrl_q[1] == $past(ctrl_q[1]))
        else $error("unmapped write changed a register");

    chk_edge_sel_stored: assert property (
        edge_wr |=> edge_sel_q == $past(wb_dat_i[7:0]))
        else $error("edge selection not stored");

    // Hardware never clears a flag nor touches an enable bit
    chk_flags_sticky: assert property (
        !wr_hit[2] |=> (ctrl_q[2] & $past(ctrl_q[2])) == $past(ctrl_q[2]))
        else $error("flag cleared without a write");

    chk_primary_enables_held: assert property (
        !wr_hit[0] |=> ctrl_q[0][3:0] == $past(ctrl_q[0][3:0]))
        else $error("primary enable changed without a write");

    chk_secondary_enables_held: assert property (
        !wr_hit[1] |=> ctrl_q[1][3:0] == $past(ctrl_q[1][3:0]))
        else $error("secondary enable changed without a write");

    chk_tertiary_enables_held: assert property (
        !wr_hit[2] |=> ctrl_q[2][3:0] == $past(ctrl_q[2][3:0]))
        else $error("tertiary enable changed without a write");

    chk_extra_enables_held: assert property (
        !wr_hit[3] |=> ctrl_q[3][1:0] == $past(ctrl_q[3][1:0]))
        else $error("extra pin enable changed without a write");

    // Every source lands at its own flag bit
    chk_cmp_one_flag: assert property (
        cmp_evt_i[1] |=> ctrl_q[1][pic_pkg::BIT_CMP_ONE_F])
        else $error("comparator 1 flag not at bit 4");

    chk_adc_flag: assert property (
        adc_evt_i |=> ctrl_q[1][pic_pkg::BIT_ADC_F])
        else $error("converter flag not at bit 7");

    chk_mf_three_flag: assert property (
        mf_evt_i[3] |=> ctrl_q[2][pic_pkg::BIT_MF_THREE_F])
        else $error("multi-function 3 flag not at bit 7");

    chk_tb_zero_flag: assert property (
        tb_evt_i[0] |=> ctrl_q[2][pic_pkg::BIT_TB_ZERO_F])
        else $error("time base 0 flag not at bit 5");

    chk_pin_zero_flag: assert property (
        ext_evt[0] |=> ctrl_q[0][pic_pkg::BIT_EXT_ZERO_F])
        else $error("pin 0 edge did not set its flag");

    chk_pin_two_flag: assert property (
        EXTRA_PINS && ext_evt[2] |=> ctrl_q[3][pic_pkg::BIT_EXT_TWO_F])
        else $error("pin 2 flag not at bit 4");

    // Request line and vector
    chk_irq_needs_pending: assert property (
        irq_o |-> $past(any_pend) && $past(ctrl_q[0][pic_pkg::BIT_GLOBAL_E]))
        else $error("request without an enabled pending flag");

    chk_vec_top_priority: assert property (
        src_pend[0] |=> irq_vec_o == 4'h0)
        else $error("highest priority source not chosen");

    // Main scenarios
    cov_irq_raised: cover property (!irq_o ##1 irq_o);
    cov_write_read: cover property (wr_hit[0] ##2 bus_req && !wb_we_i);
    cov_pin_event: cover property (|ext_evt ##1 irq_o);
    cov_unmapped_read: cover property (bus_req && !wb_we_i && wb_adr_i[7:2] > 6'h04);
    cov_pin_both: cover property (ext_evt[0] && edge_sel_q[1:0] == pic_pkg::EDGE_BOTH);

endmodule : pic_intc_regs

// >>> bench/pic_src_model.sv
module pic_src_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Requests from the bench
    input  wire logic [8:0] fire_i,
    input  wire logic [3:0] pin_i,
    // Event pulses and pin levels
    output logic [1:0]      cmp_evt_o,
    output logic            adc_evt_o,
    output logic [3:0]      mf_evt_o,
    output logic [1:0]      tb_evt_o,
    output logic [3:0]      ext_pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] fire_q;
    logic [8:0] pulse_q;
    // Sources emit one-cycle pulses, however long the bench holds a request
    always_ff @(posedge clk_i) begin
        fire_q  <= rst_i ? 9'h000 : fire_i;
        pulse_q <= rst_i ? 9'h000 : fire_i & ~fire_q;
    end
    assign {tb_evt_o, mf_evt_o, adc_evt_o, cmp_evt_o} = pulse_q;
    assign ext_pin_o = pin_i;
endmodule : pic_src_model

// >>> bench/primary_interrupt_ctrl_regs_tb.sv
module primary_interrupt_ctrl_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i, cyc, stb, we, irq;
    logic [7:0] adr;
    logic [3:0] sel, pin, vec;
    logic [31:0] dat_w, dat_r;
    logic ack;
    logic [8:0] fire;
    logic [1:0] cmp_e, tb_e;
    logic adc_e;
    logic [3:0] mf_e, ext;
    int fails = 0, n_compared = 0, seed = 14;
    int mdl[5];
    // Priority order of sources and where each flag sits
    int PR_REG[13] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3};
    int PR_BIT[13] = '{4, 5, 6, 4, 5, 6, 7, 4, 5, 6, 7, 4, 5};
    int EV_REG[9] = '{0, 1, 1, 1, 1, 2, 2, 2, 2};
    int EV_BIT[9] = '{6, 4, 7, 5, 6, 4, 7, 5, 6};
    int PN_REG[4] = '{0, 0, 3, 3};
    int PN_BIT[4] = '{4, 5, 4, 5};

    always #25 clk_i = ~clk_i;

    pic_src_model i_pic_src_model (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .pin_i(pin),
        .cmp_evt_o(cmp_e), .adc_evt_o(adc_e), .mf_evt_o(mf_e), .tb_evt_o(tb_e), .ext_pin_o(ext));

    pic_intc_regs i_pic_intc_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .cmp_evt_i(cmp_e), .adc_evt_i(adc_e), .mf_evt_i(mf_e),
        .tb_evt_i(tb_e), .ext_pin_i(ext), .irq_o(irq), .irq_vec_o(vec));

    function automatic logic [7:0] msk(input int i);
        case (i)
            0: msk = pic_pkg::MASK_PRIMARY;
            1: msk = pic_pkg::MASK_SECONDARY;
            2: msk = pic_pkg::MASK_TERTIARY;
            3: msk = pic_pkg::MASK_EXTRA;
            4: msk = pic_pkg::MASK_EDGE_SEL;
            default: msk = 8'h00;
        endcase
    endfunction : msk

    task automatic xfer(input logic w, input int i, input logic [7:0] d, input logic [3:0] s,
                        output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= 8'(i * 4);
        sel <= s;
        dat_w <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        rd = dat_r[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_irq();
        logic [4:0] exp;
        exp = 5'h00;
        // The request is registered after the flags, so let two edges pass
        repeat (2) @(posedge clk_i);
        for (int k = 12; k >= 0; k--) begin
            if (mdl[PR_REG[k]][PR_BIT[k]] && mdl[PR_REG[k]][PR_BIT[k] - (PR_REG[k] == 0 ? 3 : 4)]
                && mdl[0][0])
                exp = {1'b1, 4'(k)};
        end
        n_compared++;
        if ({irq, exp[4] ? vec : 4'h0} !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {irq, vec}, exp);
        end
    endtask : chk_irq

    task automatic wr(input int i, input logic [7:0] d, input logic [3:0] s);
        logic [7:0] rd;
        xfer(1'b1, i, d, s, rd);
        if (s[0] && i < 5) mdl[i] = d & msk(i);
    endtask : wr

    task automatic rd_chk(input int i);
        logic [7:0] rd;
        xfer(1'b0, i, 8'h00, 4'hF, rd);
        chk_reg(rd, i < 5 ? 8'(mdl[i]) & msk(i) : 8'h00);
    endtask : rd_chk

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    initial begin
        #2000000;
        fails++;
        summarize();
    end

    initial begin
        logic [31:0] r;
        rst_i = 1'b1;
        {cyc, stb, we, adr, sel, dat_w, fire, pin} = '0;
        mdl = '{0, 0, 0, 0, 0};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) rd_chk(i);
        chk_irq();
        $display("test reset done");
        for (int k = 0; k < 9; k++) begin
            @(posedge clk_i);
            fire[k] <= 1'b1;
            @(posedge clk_i);
            fire[k] <= 1'b0;
            repeat (3) @(posedge clk_i);
            mdl[EV_REG[k]][EV_BIT[k]] = 1'b1;
            rd_chk(EV_REG[k]);
        end
        chk_irq();
        wr(1, 8'(mdl[1]) | 8'h01, 4'h1);
        rd_chk(1);
        chk_irq();
        wr(0, 8'(mdl[0]) | 8'h01, 4'h1);
        chk_irq();
        wr(0, 8'h7F, 4'hE);
        rd_chk(0);
        $display("test events done");
        for (int p = 0; p < 4; p++) begin
            for (int m = 0; m < 4; m++) begin
                wr(4, 8'(m << (2 * p)), 4'h1);
                repeat (2) begin
                    @(posedge clk_i);
                    pin[p] <= ~pin[p];
                    repeat (6) @(posedge clk_i);
                    if (m[pin[p] ? 0 : 1]) mdl[PN_REG[p]][PN_BIT[p]] = 1'b1;
                    rd_chk(PN_REG[p]);
                    wr(PN_REG[p], 8'h00, 4'h1);
                end
            end
        end
        $display("test edges done");
        for (int n = 0; n < 60; n++) begin
            r = $random(seed);
            wr(int'(r[15:0]) % 6, r[23:16], r[27:24]);
            rd_chk(int'(r[15:0]) % 6);
            chk_irq();
        end
        $display("test random done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        mdl = '{0, 0, 0, 0, 0};
        for (int i = 0; i < 5; i++) rd_chk(i);
        chk_irq();
        $display("test second reset done");
        summarize();
    end
endmodule : primary_interrupt_ctrl_regs_tb
